// ### design/prsl_consts.vh
// prsl_consts.vh: register indices, field positions, reset values and timing
// for the rmii strap, led and interrupt pin block.
// assumes: included by bare name from the led and pin design files.
`ifndef PRSL_CONSTS_VH
`define PRSL_CONSTS_VH
// =====================================================
// register indices (byte address is four times index)
`define PRSL_IDX_CTRL 5'h00
`define PRSL_IDX_STRAP 5'h01
`define PRSL_IDX_INT 5'h1B
`define PRSL_IDX_LED 5'h1E
`define PRSL_IDX_PHYC 5'h1F
// =====================================================
// field positions
`define PRSL_CTRL_DUPLEX 8
`define PRSL_CTRL_ISO 10
`define PRSL_CTRL_ANEG 12
`define PRSL_STRAP_HI 2
`define PRSL_LED_LO 14
`define PRSL_LED_HI 15
`define PRSL_PHYC_POL 9
`define PRSL_INT_EN_LO 8
`define PRSL_INT_EN_HI 11
`define PRSL_INT_ST_HI 3
`define PRSL_EV_LINK_UP 0
`define PRSL_EV_LINK_DOWN 1
`define PRSL_EV_RX_ERR 2
`define PRSL_EV_TX_START 3
// =====================================================
// reset values and led modes
`define PRSL_LED_MODE_RST 2'h0
`define PRSL_LED_MODE_LINK_ACT 2'h0
`define PRSL_LED_MODE_LINK 2'h1
`define PRSL_ZERO32 32'h0000_0000
// =====================================================
// timing: blink half period in ms at the pclk rate
`define PRSL_CLK_HZ 10000000
`define PRSL_BLINK_MS 100
`define PRSL_BLINK_CYCLES (`PRSL_BLINK_MS * (`PRSL_CLK_HZ / 1000))
`endif

// ### design/prsl_sync.v
// prsl_sync.v: three-flop synchroniser for a group of pin inputs.
// assumes: inputs are asynchronous to pclk; no reset, so strap levels
// propagate while the chip is held in reset.
`timescale 1ns/1ps
module prsl_sync #(
  parameter W = 1
) (
  input wire pclk,
  input wire [W-1:0] din,
  output reg [W-1:0] dout
);
  reg [W-1:0] s1;
  reg [W-1:0] s2;
  reg [W-1:0] s3;

  // =====================================================
  // three stages; output follows once stages two and three agree
  always @(posedge pclk)
  begin
    s1 <= din;
    s2 <= s1;
    s3 <= s2;
    dout <= (s2 & s3) | (dout & (s2 ^ s3));
  end
endmodule

// ### design/prsl_led.v
// prsl_led.v: link/activity indicator driver.
// assumes: link and activity are pclk-domain levels from the phy core.
`timescale 1ns/1ps
`include "prsl_consts.vh"
module prsl_led #(
  parameter BLINK_CYCLES = `PRSL_BLINK_CYCLES
) (
  input wire pclk,
  input wire presetn,
  input wire [1:0] mode,
  input wire link_up,
  input wire activity,
  output reg led
);
  reg [31:0] cnt;
  reg blink;

  // =====================================================
  // blink generator, free running; activity gates it below
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt <= `PRSL_ZERO32;
      blink <= 1'b0;
    end
    else if (cnt >= BLINK_CYCLES - 1)
    begin
      cnt <= `PRSL_ZERO32;
      blink <= ~blink;
    end
    else
      cnt <= cnt + 32'h0000_0001;
  end

  // =====================================================
  // pin level per mode: high is off, low is on
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      led <= 1'b1;
    else if (mode == `PRSL_LED_MODE_LINK_ACT)
      led <= ~link_up | (activity & blink);
    else if (mode == `PRSL_LED_MODE_LINK)
      led <= ~link_up;
    else
      led <= 1'b1; // reserved modes leave the led off
  end
endmodule

// ### design/prsl_pins.v
// prsl_pins.v: rmii pin logic with strap capture, reference clock out,
// interrupt pin and indicator led, registers reached over apb.
// assumes: pclk 10 MHz; ref_clk_in slower than pclk / 4; core side on pclk.
// Functional notes
// - rxd0 level at reset becomes duplex bit
// - three op mode straps held; crs_dv gives bit2
// - rx_er level at reset becomes isolate
// - led pin level at reset becomes autoneg
// - reference clock always driven to mac
// - interrupt polarity from 1Fh bit 9
// - 1Bh holds interrupt enables and status
// - led meaning chosen by 1Eh bits 15:14
// - led modes: link/activity, link, reserved off
// - crs_dv driven as output after reset unless isolate is set
// - rx_er driven as receive error after reset unless isolate is set
// - rxd0 driven as receive data bit 0
// - strap pins inputs in reset, outputs after; rxd0, crs_dv and rx_er stay inputs while isolate is set
// - two rx bits per ref clock with crs_dv
`timescale 1ns/1ps
`include "prsl_consts.vh"
module prsl_pins #(
  parameter BLINK_CYCLES = `PRSL_BLINK_CYCLES
) (
  input wire pclk,
  input wire presetn,
  input wire [7:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire ref_clk_in,
  output reg ref_clk_out,
  input wire rxd0_in,
  output reg rxd0_out,
  output reg rxd0_oe,
  output reg rxd1,
  input wire crs_dv_in,
  output reg crs_dv_out,
  output reg crs_dv_oe,
  input wire rx_er_in,
  output reg rx_er_out,
  output reg rx_er_oe,
  input wire link_indicator_output_in,
  output reg link_indicator_output_out,
  output reg link_indicator_output_oe,
  input wire op_mode_strap_bit0,
  input wire op_mode_strap_bit1,
  input wire tx_en,
  input wire [1:0] txd,
  input wire core_rx_dv,
  input wire [1:0] core_rxd,
  input wire core_rx_err,
  input wire core_link_up,
  input wire core_activity,
  output reg core_tx_valid,
  output reg [1:0] core_txd,
  output reg duplex,
  output reg isolate,
  output reg autoneg_enable,
  output reg [2:0] op_mode,
  output reg irq,
  output reg interrupt_pin
);
  wire [9:0] pin_s;
  wire ref_s;
  wire tx_en_s;
  wire [1:0] txd_s;
  wire led_level;
  reg ref_d;
  reg tx_en_d;
  reg strap_done;
  reg [1:0] led_mode;
  reg int_pol;
  reg [3:0] int_en;
  reg [3:0] int_st;
  reg link_d;
  reg [3:0] next_ev;
  reg [31:0] next_rdata;
  reg next_err;
  wire ref_rise;
  wire acc;
  wire wr;
  wire irq_lvl;

  // =====================================================
  // register index of an aligned in-range byte address
  function [5:0] reg_idx;
    input [7:0] a;
    begin
      reg_idx = (a[1:0] == 2'h0) ? {1'b0, a[6:2]} : 6'h3F;
    end
  endfunction

  // =====================================================
  // all off-domain inputs pass the synchroniser
  prsl_sync #(
    .W(10)
  ) u_sync (
    .pclk(pclk),
    .din({op_mode_strap_bit1, op_mode_strap_bit0, link_indicator_output_in, rx_er_in,
      crs_dv_in, rxd0_in, txd, tx_en, ref_clk_in}),
    .dout(pin_s)
  );
  assign ref_s = pin_s[0];
  assign tx_en_s = pin_s[1];
  assign txd_s = pin_s[3:2];
  assign ref_rise = ref_s & ~ref_d;

  // =====================================================
  // indicator led driver
  prsl_led #(
    .BLINK_CYCLES(BLINK_CYCLES)
  ) u_led (
    .pclk(pclk),
    .presetn(presetn),
    .mode(led_mode),
    .link_up(core_link_up),
    .activity(core_activity),
    .led(led_level)
  );

  // =====================================================
  // strap capture at the first edge after reset release
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      strap_done <= 1'b0;
      op_mode <= 3'h0;
    end
    else if (!strap_done)
    begin
      strap_done <= 1'b1;
      op_mode <= {pin_s[5], pin_s[9], pin_s[8]};
    end
  end

  // =====================================================
  // pin direction: inputs during reset, outputs after; isolate keeps rxd0, crs_dv and rx_er as inputs
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rxd0_oe <= 1'b0;
      crs_dv_oe <= 1'b0;
      rx_er_oe <= 1'b0;
      link_indicator_output_oe <= 1'b0;
    end
    else
    begin
      rxd0_oe <= strap_done & ~isolate;
      crs_dv_oe <= strap_done & ~isolate;
      rx_er_oe <= strap_done & ~isolate;
      link_indicator_output_oe <= strap_done;
    end
  end

  // =====================================================
  // reference clock forward and rmii receive/transmit timing
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ref_d <= 1'b0;
      ref_clk_out <= 1'b0;
      rxd0_out <= 1'b0;
      rxd1 <= 1'b0;
      crs_dv_out <= 1'b0;
      rx_er_out <= 1'b0;
      tx_en_d <= 1'b0;
      core_tx_valid <= 1'b0;
      core_txd <= 2'h0;
      link_indicator_output_out <= 1'b1;
    end
    else
    begin
      ref_d <= ref_s;
      ref_clk_out <= ref_s;
      link_indicator_output_out <= led_level;
      core_tx_valid <= ref_rise & tx_en_s;
      if (ref_rise)
      begin
        crs_dv_out <= core_rx_dv;
        rx_er_out <= core_rx_err;
        rxd0_out <= core_rx_dv & core_rxd[0];
        rxd1 <= core_rx_dv & core_rxd[1];
        tx_en_d <= tx_en_s;
        if (tx_en_s)
          core_txd <= txd_s;
      end
    end
  end

  // =====================================================
  // event detection in the pclk domain
  always @*
  begin
    next_ev = 4'h0;
    next_ev[`PRSL_EV_LINK_UP] = core_link_up & ~link_d;
    next_ev[`PRSL_EV_LINK_DOWN] = ~core_link_up & link_d;
    next_ev[`PRSL_EV_RX_ERR] = ref_rise & core_rx_err;
    next_ev[`PRSL_EV_TX_START] = ref_rise & tx_en_s & ~tx_en_d;
  end

  // =====================================================
  // apb decode and read mux
  assign acc = psel & penable;
  assign wr = acc & pready & pwrite;
  always @*
  begin
    next_rdata = `PRSL_ZERO32;
    next_err = 1'b0;
    if (paddr[7] || reg_idx(paddr) == 6'h3F)
      next_err = 1'b1;
    else if (reg_idx(paddr) == {1'b0, `PRSL_IDX_CTRL})
    begin
      next_rdata[`PRSL_CTRL_DUPLEX] = duplex;
      next_rdata[`PRSL_CTRL_ISO] = isolate;
      next_rdata[`PRSL_CTRL_ANEG] = autoneg_enable;
    end
    else if (reg_idx(paddr) == {1'b0, `PRSL_IDX_STRAP})
      next_rdata[`PRSL_STRAP_HI:0] = op_mode;
    else if (reg_idx(paddr) == {1'b0, `PRSL_IDX_INT})
    begin
      next_rdata[`PRSL_INT_EN_HI:`PRSL_INT_EN_LO] = int_en;
      next_rdata[`PRSL_INT_ST_HI:0] = int_st;
    end
    else if (reg_idx(paddr) == {1'b0, `PRSL_IDX_LED})
      next_rdata[`PRSL_LED_HI:`PRSL_LED_LO] = led_mode;
    else if (reg_idx(paddr) == {1'b0, `PRSL_IDX_PHYC})
      next_rdata[`PRSL_PHYC_POL] = int_pol;
    else
      next_err = 1'b1;
  end

  // =====================================================
  // apb answer: one wait state, then pready with data
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      prdata <= `PRSL_ZERO32;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= acc & ~pready;
      pslverr <= acc & ~pready & next_err;
      if (acc && !pready && !pwrite)
        prdata <= next_rdata;
    end
  end

  // =====================================================
  // register writes; straps seed control bits once
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      duplex <= 1'b0;
      isolate <= 1'b0;
      autoneg_enable <= 1'b0;
      led_mode <= `PRSL_LED_MODE_RST;
      int_pol <= 1'b0;
      int_en <= 4'h0;
    end
    else if (!strap_done)
    begin
      duplex <= pin_s[4];
      isolate <= pin_s[6];
      autoneg_enable <= pin_s[7];
    end
    else if (wr && !next_err)
    begin
      if (reg_idx(paddr) == {1'b0, `PRSL_IDX_CTRL})
      begin
        duplex <= pwdata[`PRSL_CTRL_DUPLEX];
        isolate <= pwdata[`PRSL_CTRL_ISO];
        autoneg_enable <= pwdata[`PRSL_CTRL_ANEG];
      end
      else if (reg_idx(paddr) == {1'b0, `PRSL_IDX_INT})
        int_en <= pwdata[`PRSL_INT_EN_HI:`PRSL_INT_EN_LO];
      else if (reg_idx(paddr) == {1'b0, `PRSL_IDX_LED})
        led_mode <= pwdata[`PRSL_LED_HI:`PRSL_LED_LO];
      else if (reg_idx(paddr) == {1'b0, `PRSL_IDX_PHYC})
        int_pol <= pwdata[`PRSL_PHYC_POL];
    end
  end

  // =====================================================
  // sticky status, write one to clear, set wins
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      int_st <= 4'h0;
      link_d <= 1'b0;
    end
    else
    begin
      link_d <= core_link_up;
      if (wr && reg_idx(paddr) == {1'b0, `PRSL_IDX_INT} && !paddr[7])
        int_st <= (int_st & ~pwdata[`PRSL_INT_ST_HI:0]) | next_ev;
      else
        int_st <= int_st | next_ev;
    end
  end

  // =====================================================
  // interrupt outputs with programmable pin polarity
  assign irq_lvl = |(int_st & int_en);
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq <= 1'b0;
      interrupt_pin <= 1'b1;
    end
    else
    begin
      irq <= irq_lvl;
      interrupt_pin <= int_pol ? irq_lvl : ~irq_lvl;
    end
  end
endmodule

// ### test/prsl_mac_model.sv
// mac transmit side: one four dibit frame while go is high
// assumes: ref_clk runs free from the bench
`timescale 1ns/1ps
module prsl_mac_model(
  input wire ref_clk,
  input wire go,
  output reg tx_en,
  output reg [1:0] txd
);
  reg [2:0] cnt;
  initial
  begin
    tx_en = 1'b0;
    txd = 2'h0;
    cnt = 3'h0;
  end
  // change mid period so data is settled at the rise
  always @(negedge ref_clk)
  begin
    if (go && cnt != 3'h4)
    begin
      tx_en <= 1'b1;
      txd <= cnt[1:0];
      cnt <= cnt + 3'h1;
    end
    else
    begin
      tx_en <= 1'b0;
      txd <= ~txd; // idle data keeps moving
      if (!go)
        cnt <= 3'h0;
    end
  end
endmodule

// ### test/prsl_pins_sva.sv
// assertions on the pin block ports
// assumes: bound to prsl_pins by the bench
`timescale 1ns/1ps
module prsl_pins_sva(
  input wire pclk,
  input wire presetn,
  input wire [7:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  input wire pready,
  input wire ref_clk_in,
  input wire ref_clk_out,
  input wire rxd0_in,
  input wire rxd0_out,
  input wire rxd1,
  input wire crs_dv_in,
  input wire crs_dv_out,
  input wire crs_dv_oe,
  input wire rx_er_in,
  input wire link_indicator_output_in,
  input wire link_indicator_output_oe,
  input wire op_mode_strap_bit0,
  input wire op_mode_strap_bit1,
  input wire core_tx_valid,
  input wire duplex,
  input wire isolate,
  input wire autoneg_enable,
  input wire [2:0] op_mode,
  input wire irq,
  input wire interrupt_pin
);
  reg [2:0] cnt;
  reg pol;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // =====================================
  // edges since release, polarity shadow
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt <= 3'h0;
      pol <= 1'b0;
    end
    else
    begin
      if (cnt != 3'h7)
        cnt <= cnt + 3'h1;
      if (psel && penable && pready && pwrite && paddr == 8'h7C)
        pol <= pwdata[9];
    end
  end
  // =====================================
  // assertions
  property p_strap_ctrl;
    cnt == 3'h1 |-> duplex == rxd0_in && isolate == rx_er_in && autoneg_enable == link_indicator_output_in;
  endproperty
  a_strap_ctrl: assert property (p_strap_ctrl) else $error("strap ctrl");
  property p_strap_mode;
    cnt == 3'h1 |-> op_mode == {crs_dv_in, op_mode_strap_bit1, op_mode_strap_bit0};
  endproperty
  a_strap_mode: assert property (p_strap_mode) else $error("strap mode");
  property p_mode_hold;
    cnt == 3'h7 |-> $stable(op_mode);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode moved");
  property p_pins_out;
    $rose(presetn) |-> !link_indicator_output_oe ##[1:3] link_indicator_output_oe;
  endproperty
  a_pins_out: assert property (p_pins_out) else $error("pin drive");
  property p_isolate;
    isolate ##1 isolate |-> !crs_dv_oe;
  endproperty
  a_isolate: assert property (p_isolate) else $error("isolate");
  property p_rxd_idle;
    crs_dv_oe && !crs_dv_out |-> !rxd0_out && !rxd1;
  endproperty
  a_rxd_idle: assert property (p_rxd_idle) else $error("rxd idle");
  property p_ref_out;
    $rose(ref_clk_in) |-> ##[3:7] ref_clk_out;
  endproperty
  a_ref_out: assert property (p_ref_out) else $error("ref out");
  property p_irq_pin;
    $rose(irq) |-> ##[0:2] interrupt_pin == pol;
  endproperty
  a_irq_pin: assert property (p_irq_pin) else $error("irq pin");
  property p_apb;
    psel && penable && !pready |=> pready ##1 !pready;
  endproperty
  a_apb: assert property (p_apb) else $error("apb answer");
  property p_tx_pulse;
    core_tx_valid |=> !core_tx_valid;
  endproperty
  a_tx_pulse: assert property (p_tx_pulse) else $error("tx pulse");
endmodule

// ### test/prsl_pins_test.sv
// self-checking bench for the pin block
// assumes: design, checker and mac model compiled first
`timescale 1ns/1ps
`include "prsl_consts.vh"
`define CHK(a, b) begin num_checks = num_checks + 1; if ((a) !== (b)) begin n_fail = n_fail + 1; \
$display("wrong value at %0t: mismatch", $time); end end
module prsl_pins_test;
  reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, ref_clk = 0, go = 0;
  reg s_rxd0 = 1, s_crs = 0, s_rxer = 0, s_led = 1, b0 = 0, b1 = 0;
  reg rx_dv = 0, rx_err = 0, link = 0, act = 0, e;
  reg [7:0] paddr = 0;
  reg [31:0] pwdata = 0, q;
  reg [1:0] rxd = 0;
  wire [31:0] prdata;
  wire [1:0] txd, ctxd;
  wire [2:0] op_mode;
  wire pready, pslverr, ref_out, rxd0_out, rxd0_oe, rxd1, crs_out, crs_oe, rxer_out, rxer_oe;
  wire led_out, led_oe, tx_en, txv, duplex, isolate, aneg, irq, ipin;
  integer n_fail = 0, num_checks = 0, m, hi, lo;
  // pins resolve between device drive and strap level
  wire rxd0_pin = rxd0_oe ? rxd0_out : s_rxd0;
  wire crs_pin = crs_oe ? crs_out : s_crs;
  wire rxer_pin = rxer_oe ? rxer_out : s_rxer;
  wire led_pin = led_oe ? led_out : s_led;
  prsl_pins #(.BLINK_CYCLES(8)) u_dut(.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ref_clk_in(ref_clk), .ref_clk_out(ref_out), .rxd0_in(rxd0_pin), .rxd0_out(rxd0_out), .rxd0_oe(rxd0_oe),
    .rxd1(rxd1), .crs_dv_in(crs_pin), .crs_dv_out(crs_out), .crs_dv_oe(crs_oe), .rx_er_in(rxer_pin),
    .rx_er_out(rxer_out), .rx_er_oe(rxer_oe), .link_indicator_output_in(led_pin),
    .link_indicator_output_out(led_out), .link_indicator_output_oe(led_oe), .op_mode_strap_bit0(b0),
    .op_mode_strap_bit1(b1), .tx_en(tx_en), .txd(txd), .core_rx_dv(rx_dv), .core_rxd(rxd),
    .core_rx_err(rx_err), .core_link_up(link), .core_activity(act), .core_tx_valid(txv), .core_txd(ctxd),
    .duplex(duplex), .isolate(isolate), .autoneg_enable(aneg), .op_mode(op_mode), .irq(irq),
    .interrupt_pin(ipin));
  prsl_mac_model u_mac(.ref_clk(ref_clk), .go(go), .tx_en(tx_en), .txd(txd));
  // clocks
  always #50 pclk = ~pclk;
  initial
  begin
    #37;
    forever #400 ref_clk = ~ref_clk;
  end
  function [7:0] ad(input [4:0] i);
    ad = {1'b0, i, 2'b00};
  endfunction
  // one apb transfer, result in q and e
  task apb(input [7:0] a, input w, input [31:0] d);
    begin
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      psel <= 1'b1;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
        @(posedge pclk);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task rst(input [5:0] s);
    begin
      {s_rxd0, s_crs, s_rxer, s_led, b1, b0} <= s;
      presetn <= 1'b0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
    end
  endtask
  task t_straps;
    begin
      rst(6'b110001);
      `CHK({aneg, isolate, duplex, op_mode}, 6'b001101)
      `CHK({rxd0_oe, crs_oe, rxer_oe, led_oe}, 4'hF)
      b0 <= 1'b0;
      apb(ad(`PRSL_IDX_CTRL), 1'b0, 0);
      `CHK({q[12], q[10], q[8]}, 3'b001)
      apb(ad(`PRSL_IDX_STRAP), 1'b0, 0);
      `CHK(q[2:0], 3'b101)
      rst(6'b001110);
      `CHK({aneg, isolate, duplex, op_mode}, 6'b110010)
      `CHK({crs_oe, led_oe}, 2'b01)
      rst(6'b100000);
      apb(8'h80, 1'b0, 0);
      `CHK({e, q}, {1'b1, 32'h0000_0000})
      apb(8'h08, 1'b1, 32'hFFFF_FFFF);
      `CHK(e, 1'b1)
    end
  endtask
  task t_led;
    begin
      apb(ad(`PRSL_IDX_LED), 1'b0, 0);
      `CHK(q[15:14], 2'b00)
      link <= 1'b1;
      for (m = 1; m < 4; m = m + 1)
      begin
        apb(ad(`PRSL_IDX_LED), 1'b1, {16'h0000, m[1:0], 14'h0000});
        repeat (4) @(posedge pclk);
        `CHK(led_pin, m != 1)
      end
      apb(ad(`PRSL_IDX_LED), 1'b1, 0);
      repeat (4) @(posedge pclk);
      `CHK(led_pin, 1'b0)
      act <= 1'b1;
      hi = 0;
      lo = 0;
      repeat (40)
      begin
        @(posedge pclk);
        if (led_pin === 1'b1)
          hi = hi + 1;
        if (led_pin === 1'b0)
          lo = lo + 1;
      end
      `CHK(hi > 0 && lo > 0, 1'b1)
      act <= 1'b0;
      link <= 1'b0;
      repeat (4) @(posedge pclk);
      `CHK(led_pin, 1'b1)
    end
  endtask
  task t_irq;
    begin
      apb(ad(`PRSL_IDX_INT), 1'b1, 32'h0000_010F);
      link <= 1'b1;
      repeat (4) @(posedge pclk);
      `CHK({irq, ipin}, 2'b10)
      apb(ad(`PRSL_IDX_PHYC), 1'b1, 32'h0000_0200);
      repeat (2) @(posedge pclk);
      `CHK(ipin, 1'b1)
      apb(ad(`PRSL_IDX_INT), 1'b1, 0);
      apb(ad(`PRSL_IDX_INT), 1'b0, 0);
      `CHK({irq, q[8], q[0]}, 3'b001)
      apb(ad(`PRSL_IDX_INT), 1'b1, 32'h0000_0001);
      apb(ad(`PRSL_IDX_INT), 1'b0, 0);
      `CHK({ipin, q[0]}, 2'b00)
    end
  endtask
  task t_link;
    begin
      rx_dv <= 1'b1;
      rxd <= 2'b10;
      rx_err <= 1'b1;
      repeat (20) @(posedge pclk);
      `CHK({crs_pin, rxd1, rxd0_pin, rxer_pin}, 4'b1101)
      rxd <= 2'b01;
      rx_err <= 1'b0;
      repeat (20) @(posedge pclk);
      `CHK({crs_pin, rxd1, rxd0_pin, rxer_pin}, 4'b1010)
      rx_dv <= 1'b0;
      rxd <= 2'b11;
      repeat (20) @(posedge pclk);
      `CHK({crs_pin, rxd1, rxd0_pin}, 3'b000)
      hi = 0;
      lo = ref_out;
      repeat (80)
      begin
        @(posedge pclk);
        if (ref_out === 1'b1 && lo == 0)
          hi = hi + 1;
        lo = ref_out;
      end
      `CHK(hi, 10)
      go <= 1'b1;
      m = 0;
      repeat (100)
      begin
        @(posedge pclk);
        if (txv === 1'b1)
        begin
          `CHK(ctxd, m[1:0] + 2'h0)
          m = m + 1;
        end
      end
      `CHK(m, 4)
      go <= 1'b0;
    end
  endtask
  task end_of_test;
    begin
      if (n_fail == 0 && num_checks > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  // main sequence
  initial
  begin
    t_straps;
    t_led;
    t_irq;
    t_link;
    end_of_test;
  end
  // watchdog
  initial
  begin
    #3000000;
    n_fail = n_fail + 1;
    end_of_test;
  end
endmodule
bind prsl_pins prsl_pins_sva u_sva(.*);
